// >>> shared/timer0_defs.svh
// register indices, field positions, reset values and timing counts of the reload counter
`ifndef TIMER0_DEFS_SVH
`define TIMER0_DEFS_SVH

// register indices; byte address is four times the index
`define COUNTER_VALUE_IDX    10'h001
`define INT_ENABLE_IDX       10'h00B
`define INT_FLAGS_IDX        10'h00C
`define RELOAD_VALUE_IDX     10'h010
`define COUNTER_CONTROL_IDX  10'h011
`define MISC_FUNC_IDX        10'h19B

// counter_control fields
`define CTL_EXT_SRC_BIT      3'd7
`define CTL_PAUSE_BIT        3'd6
`define CTL_EDGE_BIT         3'd5
`define CTL_SRC_BIT          3'd4
`define CTL_PSC_MSB          2'd3

// overflow enable and flag share bit 4; counter clear is bit 5
`define OVF_BIT              3'd4
`define CLEAR_BIT            3'd5

// reset values
`define CTL_RESET            8'h00
`define BYTE_RESET           8'h00

// timing: timer mode divides pclk by 2, crystal path divides edges by 16
`define SYS_DIV              2
`define XTAL_DIV             16
`define XTAL_DIV_MAX         4'hF

`endif

// >>> shared/timer0_pkg.sv
// types shared by the reload counter modules
package timer0_pkg;

   // where the count ticks come from
   typedef enum logic [1:0] {
      src_half_sys,
      src_input_pin,
      src_crystal
   } count_source_t;

   typedef logic [7:0] byte_t;

endpackage

// >>> verilog/sync_edge.sv
// two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/10ps
module sync_edge (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic async_in,
   output logic      level_out,
   output logic      rise_pulse,
   output logic      fall_pulse
);

   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   // meta_reg feeds only sync_reg; edges are taken after the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // one pulse per edge, so one count at most per edge
   assign level_out  = sync_reg;
   assign rise_pulse = sync_reg & ~prev_reg;
   assign fall_pulse = ~sync_reg & prev_reg;

endmodule // sync_edge

// >>> verilog/pow2_prescaler.sv
// power-of-two prescaler, divide by 2**div_code for codes 0..15
`timescale 1ns/10ps
module pow2_prescaler (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       clear,
   input  wire logic       tick_in,
   input  wire logic [3:0] div_code,
   output logic            tick_out
);

   logic [14:0] count_reg;
   logic [14:0] mask;

   // low div_code bits set; all ones on the last input tick of a period
   assign mask     = ~(15'h7FFF << div_code);
   assign tick_out = tick_in & ((count_reg & mask) == mask);

   // free running; a code change mid-period can shorten or lengthen that period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= 15'h0000;
      end else if (clear) begin
         count_reg <= 15'h0000;
      end else if (tick_in) begin
         count_reg <= count_reg + 15'h0001;
      end
   end

endmodule // pow2_prescaler

// >>> verilog/reload_counter.sv
// 8-bit reload counter with prescaler, pause, clear, overflow flag and apb registers
`timescale 1ns/10ps
`include "timer0_defs.svh"

module reload_counter (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        count_input_pin,
   input  wire logic        slow_crystal_clock,
   output logic             irq
);
   import timer0_pkg::*;

   // software-visible state
   timer0_pkg::byte_t counter_value_reg;
   timer0_pkg::byte_t reload_value_reg;
   timer0_pkg::byte_t counter_control_reg;
   logic              overflow_enable_reg;
   logic              overflow_flag_reg;
   logic              counter_clear_reg;
   logic [31:0]       prdata_reg;
   logic [31:0]       prdata_next;

   // internal timing state
   logic              half_sys_reg;
   logic [3:0]        xtal_div_reg;
   logic              xtal_restart;

   // decode and bus strobes
   logic [9:0]        reg_idx;
   logic              addr_hit;
   logic              wr_access;
   logic              wr_ok;
   logic              wr_counter;
   logic              wr_enable;
   logic              wr_flags;
   logic              wr_reload;
   logic              wr_control;
   logic              wr_misc;
   timer0_pkg::byte_t rd_data;
   timer0_pkg::byte_t wr_byte;

   // counting path
   count_source_t     source;
   logic              pause_bit;
   logic              pin_rise;
   logic              pin_fall;
   logic              xtal_rise;
   logic              pin_edge;
   logic              xtal_tick;
   logic              raw_tick;
   logic              gated_tick;
   logic              count_tick;
   logic              overflow;

   // apb slave: zero wait states, error on unaligned or unmapped
   assign reg_idx = paddr[11:2];

   // registers are one byte wide and sit in byte lane 0
   assign wr_byte = pwdata[7:0];

   // only word-aligned addresses of the six registers answer
   always_comb begin
      addr_hit = 1'b0;
      if (paddr[1:0] == 2'b00) begin
         unique case (reg_idx)
            `COUNTER_VALUE_IDX,
            `INT_ENABLE_IDX,
            `INT_FLAGS_IDX,
            `RELOAD_VALUE_IDX,
            `COUNTER_CONTROL_IDX,
            `MISC_FUNC_IDX:       addr_hit = 1'b1;
            default:              addr_hit = 1'b0;
         endcase
      end
   end

   // every access completes in its first access cycle; no wait states
   assign pready    = 1'b1;
   assign pslverr   = psel & penable & ~addr_hit;
   assign prdata    = prdata_reg;

   // registers live in byte lane 0; a write without pstrb[0] stores nothing
   assign wr_access  = psel & penable & pwrite & addr_hit;
   assign wr_ok      = wr_access & pstrb[0];
   assign wr_counter = wr_ok & (reg_idx == `COUNTER_VALUE_IDX);
   assign wr_enable  = wr_ok & (reg_idx == `INT_ENABLE_IDX);
   assign wr_flags   = wr_ok & (reg_idx == `INT_FLAGS_IDX);
   assign wr_reload  = wr_ok & (reg_idx == `RELOAD_VALUE_IDX);
   assign wr_control = wr_ok & (reg_idx == `COUNTER_CONTROL_IDX);
   assign wr_misc    = wr_ok & (reg_idx == `MISC_FUNC_IDX);

   // read mux; unimplemented bits read as zero
   always_comb begin
      rd_data = `BYTE_RESET;
      unique case (reg_idx)
         `COUNTER_VALUE_IDX:   rd_data = counter_value_reg;
         `INT_ENABLE_IDX:      rd_data[`OVF_BIT] = overflow_enable_reg;
         `INT_FLAGS_IDX:       rd_data[`OVF_BIT] = overflow_flag_reg;
         `RELOAD_VALUE_IDX:    rd_data = reload_value_reg;
         `COUNTER_CONTROL_IDX: rd_data = counter_control_reg;
         `MISC_FUNC_IDX:       rd_data[`CLEAR_BIT] = counter_clear_reg;
         default:              rd_data = `BYTE_RESET;
      endcase
   end

   // read data is chosen in the setup cycle; a refused request of either
   // direction reads back zero even when its index decodes to a register
   always_comb begin
      prdata_next = prdata_reg;
      if (psel && !penable && (!pwrite || !addr_hit)) begin
         prdata_next = addr_hit ? {24'h000000, rd_data} : 32'h00000000;
      end
   end

   // captured at the end of the setup cycle so prdata comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h00000000;
      end else begin
         prdata_reg <= prdata_next;
      end
   end

   // configuration registers; all eight control bits are plain storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_control_reg <= `CTL_RESET;
      end else if (wr_control) begin
         counter_control_reg <= wr_byte;
      end
   end

   // period source for the next reload
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reload_value_reg <= `BYTE_RESET;
      end else if (wr_reload) begin
         reload_value_reg <= wr_byte;
      end
   end

   // only the overflow enable is implemented; other enable bits read zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_enable_reg <= 1'b0;
      end else if (wr_enable) begin
         overflow_enable_reg <= wr_byte[`OVF_BIT];
      end
   end

   // clear is a level: the counter stays at zero until software drops it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_clear_reg <= 1'b0;
      end else if (wr_misc) begin
         counter_clear_reg <= wr_byte[`CLEAR_BIT];
      end
   end

   // count source selection
   assign pause_bit = counter_control_reg[`CTL_PAUSE_BIT];

   // source and external selects pick one of three tick streams
   always_comb begin
      if (!counter_control_reg[`CTL_SRC_BIT]) begin
         source = src_half_sys;
      end else if (!counter_control_reg[`CTL_EXT_SRC_BIT]) begin
         source = src_input_pin;
      end else begin
         source = src_crystal;
      end
   end

   // pin is synchronised before any edge is looked at
   sync_edge pin_sync (
      .pclk       (pclk),
      .presetn    (presetn),
      .async_in   (count_input_pin),
      .level_out  (),
      .rise_pulse (pin_rise),
      .fall_pulse (pin_fall)
   );

   // the crystal is a slow level sampled by pclk, so it needs the same synchroniser
   sync_edge xtal_sync (
      .pclk       (pclk),
      .presetn    (presetn),
      .async_in   (slow_crystal_clock),
      .level_out  (),
      .rise_pulse (xtal_rise),
      .fall_pulse ()
   );

   // edge select chooses which pin transition counts
   assign pin_edge = counter_control_reg[`CTL_EDGE_BIT] ? pin_fall : pin_rise;

   // half system rate: a tick on every second pclk edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_sys_reg <= 1'b0;
      end else begin
         half_sys_reg <= ~half_sys_reg;
      end
   end

   // the divider restarts outside crystal mode and while cleared, so the first
   // crystal tick after selecting the source comes after a full sixteen edges
   assign xtal_restart = (source != src_crystal) | counter_clear_reg;

   // crystal divided by sixteen, counted on synchronised rising edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xtal_div_reg <= 4'h0;
      end else if (xtal_restart) begin
         xtal_div_reg <= 4'h0;
      end else if (xtal_rise) begin
         xtal_div_reg <= xtal_div_reg + 4'h1;
      end
   end

   // the sixteenth rising edge of a period is the one that counts
   assign xtal_tick = xtal_rise & (xtal_div_reg == `XTAL_DIV_MAX);

   // one tick stream forward; the fourth source code is never produced
   always_comb begin
      unique case (source)
         src_half_sys:  raw_tick = half_sys_reg;
         src_input_pin: raw_tick = pin_edge;
         src_crystal:   raw_tick = xtal_tick;
         default:       raw_tick = 1'b0;
      endcase
   end

   // pause stops the prescaler too, so resuming picks up where it was;
   // software should hold the prescale code at zero in counter mode
   assign gated_tick = raw_tick & ~pause_bit & ~counter_clear_reg;

   pow2_prescaler prescale (
      .pclk     (pclk),
      .presetn  (presetn),
      .clear    (counter_clear_reg),
      .tick_in  (gated_tick),
      .div_code (counter_control_reg[`CTL_PSC_MSB:0]),
      .tick_out (count_tick)
   );

   // the counter; a tick that finds it at its top value is the overflow
   assign overflow = count_tick & (counter_value_reg == 8'hFF);

   // clear beats a software write, which beats counting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_value_reg <= `BYTE_RESET;
      end else if (counter_clear_reg) begin
         counter_value_reg <= `BYTE_RESET;
      end else if (wr_counter) begin
         counter_value_reg <= wr_byte;
      end else if (overflow) begin
         counter_value_reg <= reload_value_reg;
      end else if (count_tick) begin
         counter_value_reg <= counter_value_reg + 8'h01;
      end
   end

   // overflow flag and interrupt: an overflow in the same cycle as a clearing
   // write keeps the flag set, so no event is ever lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_flag_reg <= 1'b0;
      end else if (overflow) begin
         overflow_flag_reg <= 1'b1;
      end else if (wr_flags && !wr_byte[`OVF_BIT]) begin
         overflow_flag_reg <= 1'b0;
      end
   end

   // level request while the flag is set and enabled
   assign irq = overflow_flag_reg & overflow_enable_reg;

endmodule // reload_counter

// >>> tb/reload_counter_properties.sv
// port-level checks of the reload counter: bus answers, flag and interrupt
`timescale 1ns/10ps
`include "timer0_defs.svh"
module reload_counter_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        irq
);
   logic [9:0] idx;
   logic       mapped, acc, wr, rda, en_reg, clr_reg;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // decode of the bus request
   assign idx = paddr[11:2];
   assign mapped = paddr[1:0] == 2'b00 && (idx == `COUNTER_VALUE_IDX
      || idx == `INT_ENABLE_IDX || idx == `INT_FLAGS_IDX || idx == `RELOAD_VALUE_IDX
      || idx == `COUNTER_CONTROL_IDX || idx == `MISC_FUNC_IDX);
   assign acc = psel && penable;
   assign wr = acc && pwrite && mapped && pstrb[0];
   assign rda = acc && !pwrite && mapped;
   // mirrors of bits only software changes, so they are exact
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         en_reg <= 1'b0;
      else if (wr && idx == `INT_ENABLE_IDX)
         en_reg <= pwdata[4];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         clr_reg <= 1'b0;
      else if (wr && idx == `MISC_FUNC_IDX)
         clr_reg <= pwdata[5];
   end
   a_err_unmapped: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_err_mapped: assert property (acc && mapped |-> !pslverr)
      else $error("error on mapped access");
   a_read_upper: assert property (rda |-> prdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_irq_masked: assert property (!en_reg |-> !irq)
      else $error("interrupt while disabled");
   a_irq_sticky: assert property (irq && !(wr && (idx == `INT_FLAGS_IDX
      || idx == `INT_ENABLE_IDX)) |=> irq)
      else $error("interrupt dropped without a write");
   a_flag_read: assert property (rda && idx == `INT_FLAGS_IDX && $past(irq)
      |-> prdata[4])
      else $error("flag reads clear while interrupt pending");
   a_enable_read: assert property (rda && idx == `INT_ENABLE_IDX
      |-> prdata == {27'h0, $past(en_reg), 4'h0})
      else $error("enable register readback wrong");
   a_misc_read: assert property (rda && idx == `MISC_FUNC_IDX
      |-> prdata == {26'h0, $past(clr_reg), 5'h0})
      else $error("clear register readback wrong");
   a_clear_zero: assert property (rda && idx == `COUNTER_VALUE_IDX && $past(clr_reg, 2)
      |-> prdata == 32'h0)
      else $error("counter not zero while cleared");
   c_irq: cover property ($rose(irq));
   c_err: cover property (acc && pslverr);
   c_clear: cover property (rda && idx == `COUNTER_VALUE_IDX && $past(clr_reg, 2));
endmodule // reload_counter_checker

bind reload_counter reload_counter_checker chk (.pclk(pclk), .presetn(presetn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr), .irq(irq));

// >>> tb/count_source.sv
// far-side model: pulses on the count pin and bursts of the slow crystal
`timescale 1ns/10ps
module count_source (
   input  wire logic pclk,
   output logic      pin,
   output logic      xtal
);
   // pin has a pull-up so it idles high; crystal parks low between bursts
   initial begin
      pin = 1'b1;
      xtal = 1'b0;
   end
   // low then high, each half several clocks, so every edge survives the synchroniser
   task automatic pulses(input int n, input int half);
      repeat (n) begin
         repeat (half) @(posedge pclk);
         pin <= 1'b0;
         repeat (half) @(posedge pclk);
         pin <= 1'b1;
      end
   endtask
   // n rising edges of the crystal line
   task automatic crystal(input int n, input int half);
      repeat (n) begin
         repeat (half) @(posedge pclk);
         xtal <= 1'b1;
         repeat (half) @(posedge pclk);
         xtal <= 1'b0;
      end
   endtask
endmodule // count_source

// >>> tb/reload_counter_tb.sv
// apb-driven self-checking bench for the reload counter
`timescale 1ns/10ps
`include "timer0_defs.svh"
module reload_counter_tb;
   localparam logic [11:0] adr_cnt  = {`COUNTER_VALUE_IDX, 2'b00};
   localparam logic [11:0] adr_ie   = {`INT_ENABLE_IDX, 2'b00};
   localparam logic [11:0] adr_if   = {`INT_FLAGS_IDX, 2'b00};
   localparam logic [11:0] adr_rld  = {`RELOAD_VALUE_IDX, 2'b00};
   localparam logic [11:0] adr_ctl  = {`COUNTER_CONTROL_IDX, 2'b00};
   localparam logic [11:0] adr_misc = {`MISC_FUNC_IDX, 2'b00};
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, pin, xtal, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0]  pstrb;
   int          n_errors, tests_run, cyc, t0;

   reload_counter dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .count_input_pin(pin), .slow_crystal_clock(xtal),
      .irq(irq));
   count_source src (.pclk(pclk), .pin(pin), .xtal(xtal));

   // 100 MHz clock and a free cycle count for interval timing
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) cyc <= cyc + 1;

   task automatic print_verdict;
      if (n_errors == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic give_up;
      n_errors++;
      print_verdict();
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer, then one idle cycle so back-to-back calls never clash
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k == 50)
         give_up();
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      xfer(1'b1, a, {24'h0, d}, 4'hF);
   endtask
   task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] x);
      xfer(1'b0, a, 32'h0, 4'h0);
      check(nm, q, {24'h0, x});
   endtask
   task automatic wait_irq;
      int k;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (irq !== 1'b1 && k < 5000);
      if (k == 5000)
         give_up();
   endtask
   // overflow to overflow spacing, taken from a paused, preloaded start
   task automatic period(input logic [7:0] r, input logic [3:0] n, input int exp);
      wr(adr_ctl, {4'h4, n});
      wr(adr_cnt, r);
      wr(adr_rld, r);
      wr(adr_if, 8'h00);
      wr(adr_ie, 8'h10);
      wr(adr_ctl, {4'h0, n});
      wait_irq();
      t0 = cyc;
      wr(adr_if, 8'h00);
      wait_irq();
      check("period", 32'(cyc - t0), 32'(exp));
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      n_errors = 0;
      tests_run = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // reset values, access kinds and refusals
      rchk("ie reset", adr_ie, 8'h00);
      rchk("if reset", adr_if, 8'h00);
      rchk("rld reset", adr_rld, 8'h00);
      rchk("ctl reset", adr_ctl, 8'h00);
      rchk("misc reset", adr_misc, 8'h00);
      wr(adr_ctl, 8'h40);
      rchk("ctl", adr_ctl, 8'h40);
      wr(adr_rld, 8'hA5);
      rchk("reload", adr_rld, 8'hA5);
      xfer(1'b1, adr_rld, 32'h3C, 4'hE);
      rchk("strobe off", adr_rld, 8'hA5);
      wr(adr_ie, 8'hFF);
      rchk("ie", adr_ie, 8'h10);
      wr(adr_if, 8'hFF);
      rchk("flag by write", adr_if, 8'h00);
      xfer(1'b0, 12'h008, 32'h0, 4'h0);
      check("unmapped", {q[30:0], e}, 32'h1);
      xfer(1'b1, 12'h045, 32'h0, 4'hF);
      check("unaligned", {31'h0, e}, 32'h1);
      wr(adr_cnt, 8'h33);
      repeat (40) @(posedge pclk);
      rchk("paused", adr_cnt, 8'h33);
      // flag without enable, then enable, then clear
      wr(adr_ie, 8'h00);
      wr(adr_cnt, 8'hFE);
      wr(adr_ctl, 8'h00);
      repeat (20) @(posedge pclk);
      check("irq masked", {31'h0, irq}, 32'h0);
      rchk("flag", adr_if, 8'h10);
      wr(adr_ie, 8'h10);
      check("irq on", {31'h0, irq}, 32'h1);
      wr(adr_if, 8'hEF);
      check("irq cleared", {31'h0, irq}, 32'h0);
      wr(adr_misc, 8'hFF);
      rchk("misc", adr_misc, 8'h20);
      rchk("cleared", adr_cnt, 8'h00);
      wr(adr_misc, 8'h00);
      period(8'hF0, 4'h0, 32);
      period(8'hF0, 4'h1, 64);
      period(8'h80, 4'h2, 1024);
      period(8'h00, 4'h0, 512);
      // counter mode, prescale left at zero; rising then falling pin edges
      for (int k = 0; k < 2; k++) begin
         wr(adr_ctl, {2'b01, k[0], 1'b1, 4'h0});
         wr(adr_cnt, 8'h00);
         wr(adr_ctl, {2'b00, k[0], 1'b1, 4'h0});
         src.pulses(5, 3);
         repeat (6) @(posedge pclk);
         rchk("pin edges", adr_cnt, 8'h05);
      end
      wr(adr_ctl, 8'hD0);
      wr(adr_cnt, 8'h00);
      wr(adr_ctl, 8'h90);
      src.crystal(32, 2);
      repeat (6) @(posedge pclk);
      rchk("crystal", adr_cnt, 8'h02);
      print_verdict();
   end
endmodule // reload_counter_tb
